// >>> common/wprc_pkg.sv
// Shared constants and types for the wireless power receiver control block
package wprc_pkg;
  // Converter and table geometry
  localparam int ADC_W      = 12;
  localparam int SET_W      = 24;
  localparam int FOD_SETS   = 10;
  localparam int SYNC_W     = 11;
  // Clock and sampling period
  localparam int CLK_HZ     = 40_000_000;
  localparam int SAMPLE_US  = 100;
  localparam int SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;
  // ADC scaling
  localparam int MV_PER_LSB = 5;
  localparam int MA_PER_LSB = 1;
  // Voltage and current levels
  localparam int RECTIFIED_SUPPLY_NODE_LDO_MV   = 7000;
  localparam int RECTIFIED_SUPPLY_NODE_T1_MV    = 6300;
  localparam int RECTIFIED_SUPPLY_NODE_T2_MV    = 5500;
  localparam int RECTIFIED_SUPPLY_NODE_T3_MV    = 5450;
  localparam int FULL_SYNC_MA   = 300;
  localparam int OVP_DEF_MV     = 9000;
  localparam int OVP_HYST_MV    = 500;
  localparam int BACKOFF_MV     = 500;
  localparam int DEADBAND_MV    = 50;
  localparam int COMM_LOAD_MA   = 40;
  localparam int ISET_DEF_MA    = 1000;
  // Detection offset and window
  localparam int OFFSET_MIN_MW  = -300;
  localparam int OFFSET_MAX_MW  = 300;
  localparam int OFFSET_STEP_MW = 50;
  localparam int FOD_WIN_MW     = 250;
  localparam int PWR_MUL        = 41;
  localparam int PWR_SHIFT      = 13;
  localparam int SLOPE_SHIFT    = 4;
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_VOL_SET = 8'h04;
  localparam logic [7:0] REG_OTP     = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_RECTIFIED_SUPPLY_NODE   = 8'h10;
  localparam logic [7:0] REG_IRECT   = 8'h14;
  localparam logic [7:0] REG_IOUT    = 8'h18;
  // Field positions
  localparam int CTRL_SRC_VOL = 0;
  localparam int OTP_IDX_LSB  = 24;
  localparam int SLOPE_LSB    = 0;
  localparam int ICPT_LSB     = 8;
  localparam int STS_STATE    = 0;
  localparam int STS_LDO      = 3;
  localparam int STS_RECT     = 4;
  localparam int STS_ILOAD    = 6;
  localparam int STS_TCLAMP   = 7;
  localparam int STS_ICLAMP   = 8;
  localparam int STS_STAT_N   = 9;
  localparam int STS_FOD      = 10;
  localparam int STS_UVLO_OK  = 11;
  localparam int STS_PXFER    = 12;
  // Reset values
  localparam logic [SET_W-1:0] VOL_SET_RST = 24'h00_0000;
  localparam logic [31:0]      RDATA_RST   = 32'h0000_0000;
  // Rectifier drive modes
  typedef enum logic [1:0] {RECT_DIODE, RECT_HALF, RECT_FULL} wprc_rect_e;
  // Control phases
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_RAMP, ST_RUN, ST_OVIN, ST_EPT
  } wprc_state_e;
endpackage

// >>> rtl/wprc_divider.sv
// Sample-rate divider producing a one-cycle enable
`timescale 1ns/10ps
module wprc_divider #(
  parameter int DIV = 4000
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } wprc_div_s;

  wprc_div_s s_reg;
  wprc_div_s s_next;

  if (DIV < 2) begin : g_chk
    $error("wprc_divider: DIV must be at least 2");
  end

  // Count up the period, pulse at wrap
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == CW'(DIV - 1)) begin
      s_next.cnt  = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_out = s_reg.tick;
endmodule

// >>> rtl/wprc_rx_ctrl.sv
// Wireless power receiver control: loop, regulator gate, clamps, detection
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
module wprc_rx_ctrl
  import wprc_pkg::*;
#(
  parameter int OVP_MV   = OVP_DEF_MV,
  parameter int HYST_MV  = OVP_HYST_MV,
  parameter int ISET_MA  = ISET_DEF_MA,
  parameter int DBAND_MV = DEADBAND_MV,
  parameter int LOAD_MA  = COMM_LOAD_MA
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [31:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [31:0]      reg_rdata_out,
  output logic                  adc_start_out,
  input  wire logic             adc_done_in,
  input  wire logic [ADC_W-1:0] adc_rectified_supply_node_in,
  input  wire logic [ADC_W-1:0] adc_irect_in,
  input  wire logic [ADC_W-1:0] adc_iout_in,
  input  wire logic             uvlo_ok_in,
  input  wire logic             vin_over_in,
  input  wire logic             en_pin_in,
  input  wire logic             power_xfer_in,
  input  wire logic [3:0]       detect_table_select_in,
  input  wire logic [3:0]       detect_offset_select_in,
  output logic                  freq_down_out,
  output logic                  freq_up_out,
  output logic                  ept_req_out,
  output logic                  ldo_en_out,
  output logic                  internal_load_out,
  output logic      [1:0]       rect_mode_out,
  output logic                  tank_clamp_out,
  output logic                  input_clamp_out,
  output logic                  stat_n_out,
  output logic                  fod_flag_out
);
  // Thresholds in ADC codes
  localparam logic [ADC_W-1:0] V7_CODE   = ADC_W'(RECTIFIED_SUPPLY_NODE_LDO_MV / MV_PER_LSB);
  localparam logic [ADC_W-1:0] VT1_CODE  = ADC_W'(RECTIFIED_SUPPLY_NODE_T1_MV / MV_PER_LSB);
  localparam logic [ADC_W-1:0] VT2_CODE  = ADC_W'(RECTIFIED_SUPPLY_NODE_T2_MV / MV_PER_LSB);
  localparam logic [ADC_W-1:0] VT3_CODE  = ADC_W'(RECTIFIED_SUPPLY_NODE_T3_MV / MV_PER_LSB);
  localparam logic [ADC_W-1:0] VBK_CODE  =
    ADC_W'((RECTIFIED_SUPPLY_NODE_LDO_MV - BACKOFF_MV) / MV_PER_LSB);
  localparam logic [ADC_W-1:0] OVP_CODE  = ADC_W'(OVP_MV / MV_PER_LSB);
  localparam logic [ADC_W-1:0] OVPR_CODE =
    ADC_W'((OVP_MV - HYST_MV) / MV_PER_LSB);
  localparam logic [ADC_W-1:0] DB_CODE   = ADC_W'(DBAND_MV / MV_PER_LSB);
  localparam logic [ADC_W-1:0] FULL_CODE = ADC_W'(FULL_SYNC_MA / MA_PER_LSB);
  localparam logic [ADC_W-1:0] LOAD_CODE = ADC_W'(LOAD_MA / MA_PER_LSB);
  localparam logic [15:0]      ISET_CODE = 16'(ISET_MA / MA_PER_LSB);
  localparam logic [3:0]       OFF_LAST  =
    4'((OFFSET_MAX_MW - OFFSET_MIN_MW) / OFFSET_STEP_MW);

  if (OVP_MV <= HYST_MV || HYST_MV < 1 || ISET_MA < 10 ||
      OVP_MV / MV_PER_LSB >= (1 << ADC_W) || DBAND_MV < 0 ||
      LOAD_MA < 0) begin : g_chk
    $error("wprc_rx_ctrl: parameter out of range");
  end

  typedef struct packed {
    wprc_state_e                  st;
    logic [ADC_W-1:0]             rectified_supply_node;
    logic [ADC_W-1:0]             irect;
    logic [ADC_W-1:0]             iout;
    logic                         sample_new;
    logic                         src_vol;
    logic [SET_W-1:0]             vol_set;
    logic [FOD_SETS-1:0][SET_W-1:0] otp;
    logic [FOD_SETS-1:0]          otp_used;
    logic                         adc_start;
    logic                         down;
    logic                         up;
    logic                         ept;
    logic                         ldo;
    logic                         iload;
    logic [1:0]                   rect;
    logic                         tclamp;
    logic                         iclamp;
    logic                         stat_n;
    logic                         fod;
    logic [31:0]                  rdata;
  } wprc_ctrl_s;

  wprc_ctrl_s s_reg;
  wprc_ctrl_s s_next;

  logic                rst_meta_reg;
  logic                rst_sync_reg;
  logic                tick;
  logic [SYNC_W-1:0]   pins_sync;
  logic                en_s;
  logic                vin_s;
  logic                uvlo_s;
  logic [3:0]          tsel_s;
  logic [3:0]          osel_s;
  logic [ADC_W-1:0]    target;
  logic [15:0]         iout_x10;
  logic [15:0]         iout_x5;
  logic [15:0]         iout_x10q;
  logic [3:0]          tsel_c;
  logic [3:0]          osel_c;
  logic [SET_W-1:0]    fod_set;
  logic [23:0]         prod_vi;
  logic [31:0]         meas_mw;
  logic signed [31:0]  ref_mw;
  logic signed [31:0]  off_mw;
  logic signed [31:0]  diff_mw;
  logic                act;

  // Reset release through two flops
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Asynchronous pins and selector straps
  wprc_sync #(.W(SYNC_W)) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_sync_reg),
    .pins_in    ({en_pin_in, vin_over_in, uvlo_ok_in,
                  detect_table_select_in, detect_offset_select_in}),
    .pins_out   (pins_sync)
  );

  // Periodic sample strobe
  wprc_divider #(.DIV(SAMPLE_CYC)) u_div (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_sync_reg),
    .tick_out   (tick)
  );

  assign {en_s, vin_s, uvlo_s, tsel_s, osel_s} = pins_sync;

  // Load-dependent voltage target
  always_comb begin
    iout_x10  = 16'(s_reg.iout) * 16'h000a;
    iout_x5   = 16'(s_reg.iout) * 16'h0005;
    iout_x10q = 16'(s_reg.iout) * 16'h000a;
    target    = V7_CODE;
    if (s_reg.st == ST_OVIN) begin
      target = VBK_CODE;
    end else if (s_reg.st == ST_RUN) begin
      if (iout_x10 < ISET_CODE) begin
        target = V7_CODE;
      end else if (iout_x5 < ISET_CODE) begin
        target = VT1_CODE;
      end else if (iout_x10q < 16'(ISET_CODE * 4)) begin
        target = VT2_CODE;
      end else begin
        target = VT3_CODE;
      end
    end
  end

  // Detection setting, offset and power comparison
  always_comb begin
    tsel_c  = (tsel_s < 4'(FOD_SETS)) ? tsel_s : 4'(FOD_SETS - 1);
    osel_c  = (osel_s > OFF_LAST) ? OFF_LAST : osel_s;
    fod_set = s_reg.src_vol ? s_reg.vol_set : s_reg.otp[tsel_c];
    off_mw  = 32'(OFFSET_MIN_MW) +
              32'(OFFSET_STEP_MW) * $signed({28'h000_0000, osel_c});
    prod_vi = 24'(s_reg.rectified_supply_node) * 24'(s_reg.irect);
    meas_mw = (32'(prod_vi) * 32'(PWR_MUL)) >> PWR_SHIFT;
    ref_mw  = 32'($signed(fod_set[ICPT_LSB +: 16])) + off_mw +
              $signed(32'((20'(fod_set[SLOPE_LSB +: 8]) * 20'(s_reg.irect))
                          >> SLOPE_SHIFT));
    diff_mw = $signed(meas_mw) - ref_mw;
    if (diff_mw < 0) begin
      diff_mw = -diff_mw;
    end
  end

  // Control phases, loop decisions, drives and register port
  always_comb begin
    s_next           = s_reg;
    s_next.adc_start = tick;
    s_next.down      = 1'b0;
    s_next.up        = 1'b0;
    s_next.ept       = 1'b0;
    s_next.rdata     = RDATA_RST;
    act = s_reg.sample_new &&
          (s_reg.st == ST_RAMP || s_reg.st == ST_RUN ||
           s_reg.st == ST_OVIN);

    // Loop decision from the latest sample only
    if (s_reg.sample_new) begin
      s_next.sample_new = 1'b0;
      if (act && (13'(s_reg.rectified_supply_node) + 13'(DB_CODE) < 13'(target))) begin
        s_next.down = 1'b1;
      end else if (act && (s_reg.rectified_supply_node > target + DB_CODE)) begin
        s_next.up = 1'b1;
      end
      if (s_reg.rectified_supply_node > OVP_CODE) begin
        s_next.tclamp = 1'b1;
      end else if (s_reg.rectified_supply_node < OVPR_CODE) begin
        s_next.tclamp = 1'b0;
      end
      s_next.fod = (s_reg.st == ST_RUN) &&
                   (diff_mw > 32'(FOD_WIN_MW));
    end

    // Capture a finished conversion; set wins over the clear above
    if (adc_done_in) begin
      s_next.rectified_supply_node      = adc_rectified_supply_node_in;
      s_next.irect      = adc_irect_in;
      s_next.iout       = adc_iout_in;
      s_next.sample_new = 1'b1;
    end

    // Phase sequencing, highest priority first
    if (!uvlo_s) begin
      s_next.st = ST_IDLE;
    end else if (en_s) begin
      if (s_reg.st != ST_EPT) begin
        s_next.ept = 1'b1;
      end
      s_next.st = ST_EPT;
    end else if (vin_s) begin
      s_next.st = ST_OVIN;
    end else begin
      case (s_reg.st)
        ST_IDLE: begin
          s_next.st = ST_WAIT;
        end
        ST_WAIT: begin
          if (power_xfer_in) begin
            s_next.st = ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (!power_xfer_in) begin
            s_next.st = ST_WAIT;
          end else if (s_reg.rectified_supply_node >= V7_CODE) begin
            s_next.st = ST_RUN;
          end
        end
        ST_RUN: begin
          if (!power_xfer_in) begin
            s_next.st = ST_WAIT;
          end
        end
        ST_OVIN: begin
          s_next.st = ST_WAIT;
        end
        ST_EPT: begin
          s_next.st = ST_IDLE;
        end
        default: begin
          s_next.st = ST_IDLE;
        end
      endcase
    end

    // Outputs derived from the coming phase, lockout and current samples
    s_next.ldo    = (s_next.st == ST_RUN);
    s_next.iclamp = (s_next.st == ST_OVIN);
    s_next.stat_n = (s_next.st != ST_RUN);
    if (!uvlo_s) begin
      s_next.rect = RECT_DIODE;
    end else if (s_next.irect > FULL_CODE) begin
      s_next.rect = RECT_FULL;
    end else begin
      s_next.rect = RECT_HALF;
    end
    if (s_next.st == ST_IDLE) begin
      s_next.iload = 1'b1;
    end else if (s_reg.iout >= LOAD_CODE) begin
      s_next.iload = 1'b0;
    end

    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_CTRL: begin
          s_next.src_vol = reg_wdata_in[CTRL_SRC_VOL];
        end
        REG_VOL_SET: begin
          s_next.vol_set = reg_wdata_in[SET_W-1:0];
        end
        REG_OTP: begin
          for (int i = 0; i < FOD_SETS; i++) begin
            if (reg_wdata_in[OTP_IDX_LSB +: 4] == 4'(i) &&
                !s_reg.otp_used[i]) begin
              s_next.otp[i]      = reg_wdata_in[SET_W-1:0];
              s_next.otp_used[i] = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, data in the following cycle
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_CTRL: begin
          s_next.rdata[CTRL_SRC_VOL] = s_reg.src_vol;
        end
        REG_VOL_SET: begin
          s_next.rdata[SET_W-1:0] = s_reg.vol_set;
        end
        REG_OTP: begin
          s_next.rdata[FOD_SETS-1:0] = s_reg.otp_used;
        end
        REG_STATUS: begin
          s_next.rdata[STS_STATE +: 3] = s_reg.st;
          s_next.rdata[STS_LDO]        = s_reg.ldo;
          s_next.rdata[STS_RECT +: 2]  = s_reg.rect;
          s_next.rdata[STS_ILOAD]      = s_reg.iload;
          s_next.rdata[STS_TCLAMP]     = s_reg.tclamp;
          s_next.rdata[STS_ICLAMP]     = s_reg.iclamp;
          s_next.rdata[STS_STAT_N]     = s_reg.stat_n;
          s_next.rdata[STS_FOD]        = s_reg.fod;
          s_next.rdata[STS_UVLO_OK]    = uvlo_s;
          s_next.rdata[STS_PXFER]      = power_xfer_in;
        end
        REG_RECTIFIED_SUPPLY_NODE: begin
          s_next.rdata[ADC_W-1:0] = s_reg.rectified_supply_node;
        end
        REG_IRECT: begin
          s_next.rdata[ADC_W-1:0] = s_reg.irect;
        end
        REG_IOUT: begin
          s_next.rdata[ADC_W-1:0] = s_reg.iout;
        end
        default: begin
          s_next.rdata = RDATA_RST;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      s_reg         <= '0;
      s_reg.st      <= ST_IDLE;
      s_reg.vol_set <= VOL_SET_RST;
      s_reg.iload   <= 1'b1;
      s_reg.stat_n  <= 1'b1;
      s_reg.rect    <= RECT_DIODE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_out     = s_reg.rdata;
  assign adc_start_out     = s_reg.adc_start;
  assign freq_down_out     = s_reg.down;
  assign freq_up_out       = s_reg.up;
  assign ept_req_out       = s_reg.ept;
  assign ldo_en_out        = s_reg.ldo;
  assign internal_load_out = s_reg.iload;
  assign rect_mode_out     = s_reg.rect;
  assign tank_clamp_out    = s_reg.tclamp;
  assign input_clamp_out   = s_reg.iclamp;
  assign stat_n_out        = s_reg.stat_n;
  assign fod_flag_out      = s_reg.fod;
endmodule

// >>> rtl/wprc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module wprc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] pins_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } wprc_sync_s;

  wprc_sync_s s_reg;
  wprc_sync_s s_next;

  if (W < 1) begin : g_chk
    $error("wprc_sync: W must be at least 1");
  end

  // Shift chain; output follows once stages two and three agree
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = pins_in;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.q  = (s_reg.s2 & s_reg.s3) | (s_reg.q & (s_reg.s2 | s_reg.s3));
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins_out = s_reg.q;
endmodule

// >>> test/wprc_adc_model.sv
// Converter model answering the block's conversion requests
`timescale 1ns/10ps
module wprc_adc_model
  import wprc_pkg::*;
(
  input  wire logic             clk_sys_in,
  input  wire logic             start_in,
  input  wire logic [ADC_W-1:0] v_in,
  input  wire logic [ADC_W-1:0] i_in,
  input  wire logic [ADC_W-1:0] o_in,
  output logic                  done_out,
  output logic      [ADC_W-1:0] v_out,
  output logic      [ADC_W-1:0] i_out,
  output logic      [ADC_W-1:0] o_out
);
  int wait_q = 0;
  initial done_out = 1'b0;
  // Random conversion time; codes are only valid beside done
  always @(posedge clk_sys_in) begin
    if (start_in)
      wait_q <= 2 + $urandom_range(30);
    else if (wait_q > 0)
      wait_q <= wait_q - 1;
    done_out <= (wait_q == 1);
    {v_out, i_out, o_out} <= (wait_q == 1) ? {v_in, i_in, o_in}
                                           : ~{v_in, i_in, o_in};
  end
endmodule

// >>> test/wprc_rx_ctrl_bench.sv
// Self-checking bench for the receiver control block
`timescale 1ns/10ps
module wprc_rx_ctrl_bench;
  import wprc_pkg::*;
  logic             clk_sys_in = 1'b0, rst_n_in = 1'b0;
  logic [7:0]       reg_addr_in = 8'h00;
  logic [31:0]      reg_wdata_in = 32'h0000_0000, reg_rdata_out, rdv;
  logic             reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic             adc_start_out, adc_done_in;
  logic [ADC_W-1:0] adc_rectified_supply_node_in, adc_irect_in, adc_iout_in;
  logic [ADC_W-1:0] mv = 12'h000, mi = 12'h000, mo = 12'h000;
  logic             uvlo_ok_in = 1'b1, vin_over_in = 1'b0;
  logic             en_pin_in = 1'b0, power_xfer_in = 1'b0;
  logic [3:0]       detect_table_select_in, detect_offset_select_in;
  logic             freq_down_out, freq_up_out, ept_req_out, ldo_en_out;
  logic             internal_load_out, tank_clamp_out, input_clamp_out;
  logic             stat_n_out, fod_flag_out;
  logic [1:0]       rect_mode_out;
  logic [23:0]      vs;
  int               n_fail = 0, checks_done = 0, cyc = 0;
  int               co[6] = '{99, 100, 199, 200, 399, 400};

  wprc_rx_ctrl dut (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .adc_start_out, .adc_done_in,
    .adc_rectified_supply_node_in, .adc_irect_in, .adc_iout_in, .uvlo_ok_in, .vin_over_in,
    .en_pin_in, .power_xfer_in, .detect_table_select_in,
    .detect_offset_select_in, .freq_down_out, .freq_up_out, .ept_req_out,
    .ldo_en_out, .internal_load_out, .rect_mode_out, .tank_clamp_out,
    .input_clamp_out, .stat_n_out, .fod_flag_out);
  wprc_adc_model adc (.clk_sys_in, .start_in(adc_start_out), .v_in(mv),
    .i_in(mi), .o_in(mo), .done_out(adc_done_in), .v_out(adc_rectified_supply_node_in),
    .i_out(adc_irect_in), .o_out(adc_iout_in));

  // Clock and hang guard
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    rdv = reg_rdata_out;
  endtask

  // Expected voltage target and frequency decision
  function automatic int tgt(int o);
    if (o * 10 < ISET_DEF_MA) return RECTIFIED_SUPPLY_NODE_LDO_MV / MV_PER_LSB;
    if (o * 5 < ISET_DEF_MA) return RECTIFIED_SUPPLY_NODE_T1_MV / MV_PER_LSB;
    if (o * 10 < ISET_DEF_MA * 4) return RECTIFIED_SUPPLY_NODE_T2_MV / MV_PER_LSB;
    return RECTIFIED_SUPPLY_NODE_T3_MV / MV_PER_LSB;
  endfunction
  function automatic logic [1:0] dec(int v, int t);
    return {v + DEADBAND_MV / MV_PER_LSB < t,
            v > t + DEADBAND_MV / MV_PER_LSB};
  endfunction
  // Expected detection flag from the volatile set and offset code
  function automatic logic fodx(int v, int i);
    int m, r, oc;
    oc = detect_offset_select_in > 12 ? 12 : detect_offset_select_in;
    m = (v * i * PWR_MUL) >>> PWR_SHIFT;
    r = int'($signed(vs[23:8])) + OFFSET_MIN_MW + OFFSET_STEP_MW * oc
        + ((int'(vs[7:0]) * i) >> SLOPE_SHIFT);
    return (m - r > FOD_WIN_MW) || (r - m > FOD_WIN_MW);
  endfunction

  // One conversion: decision one edge after capture, then silence
  task automatic smp(input int v, i, o, input logic [1:0] ed);
    int n;
    n = 0;
    mv <= 12'(v);
    mi <= 12'(i);
    mo <= 12'(o);
    @(posedge clk_sys_in);
    while (adc_done_in !== 1'b1 && n < 5000) begin
      @(posedge clk_sys_in);
      n++;
    end
    chk(32'(n < 5000), 32'h1);
    @(posedge clk_sys_in);
    #1;
    chk({freq_down_out, freq_up_out}, ed);
    @(posedge clk_sys_in);
    #1;
    chk({freq_down_out, freq_up_out}, 2'b00);
  endtask

  initial begin
    int k, v, i, o, n;
    logic il;
    void'($urandom(32'h8074));
    detect_table_select_in <= 4'($urandom);
    detect_offset_select_in <= 4'($urandom);
    il = 1'b1;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    chk({internal_load_out, stat_n_out, ldo_en_out}, 3'b110);
    vs = 24'($urandom);
    wr(REG_VOL_SET, {8'h00, vs});
    wr(REG_CTRL, 32'h0000_0001);
    rd(REG_VOL_SET);
    chk(rdv, {8'h00, vs});
    wr(REG_OTP, 32'h0312_3456);
    wr(REG_OTP, 32'h0c00_0001);
    rd(REG_OTP);
    chk(rdv, 32'h0000_0008);
    rd(8'h20);
    chk(rdv, 32'h0000_0000);
    smp(1200, 100, 10, 2'b00);
    power_xfer_in <= 1'b1;
    smp(1200, 100, 10, 2'b10);
    smp(1405, 100, 10, 2'b00);
    chk({ldo_en_out, stat_n_out}, 2'b10);
    // Load steps at region edges, then random loads
    for (k = 0; k < 8; k++) begin
      o = k < 6 ? co[k] : int'($urandom_range(600));
      i = int'($urandom_range(450, 150));
      v = tgt(o) + int'($urandom_range(24)) - 12;
      il = il && o < COMM_LOAD_MA;
      smp(v, i, o, dec(v, tgt(o)));
      chk(rect_mode_out, i > FULL_SYNC_MA ? 2'h2 : 2'h1);
      chk(internal_load_out, il);
      chk(fod_flag_out, fodx(v, i));
    end
    smp(1850, 200, 500, 2'b01);
    chk(tank_clamp_out, 1'b1);
    smp(1750, 200, 500, 2'b01);
    chk(tank_clamp_out, 1'b1);
    smp(1650, 200, 500, 2'b01);
    chk(tank_clamp_out, 1'b0);
    vin_over_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    chk({input_clamp_out, ldo_en_out}, 2'b10);
    smp(1350, 100, 500, 2'b01);
    smp(1280, 100, 500, 2'b10);
    vin_over_in <= 1'b0;
    smp(1400, 100, 500, 2'b00);
    chk(ldo_en_out, 1'b1);
    en_pin_in <= 1'b1;
    n = 0;
    repeat (12) begin
      @(posedge clk_sys_in);
      #1;
      n += int'(ept_req_out);
    end
    chk(n, 1);
    chk(ldo_en_out, 1'b0);
    en_pin_in <= 1'b0;
    uvlo_ok_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    chk({rect_mode_out, internal_load_out}, 3'b001);
    report_and_stop();
  end
endmodule

bind wprc_rx_ctrl wprc_rx_ctrl_checker #(.OVP_MV(OVP_MV), .HYST_MV(HYST_MV))
  chk_i (.clk_sys_in, .rst_n_in, .adc_done_in, .adc_rectified_supply_node_in, .uvlo_ok_in,
    .vin_over_in, .en_pin_in, .power_xfer_in, .freq_down_out, .freq_up_out,
    .ept_req_out, .ldo_en_out, .rect_mode_out, .tank_clamp_out,
    .input_clamp_out, .stat_n_out);

// >>> test/wprc_rx_ctrl_checker.sv
// Property checker for the receiver control ports
`timescale 1ns/10ps
module wprc_rx_ctrl_checker
  import wprc_pkg::*;
#(
  parameter int OVP_MV  = OVP_DEF_MV,
  parameter int HYST_MV = OVP_HYST_MV
) (
  input wire logic             clk_sys_in,
  input wire logic             rst_n_in,
  input wire logic             adc_done_in,
  input wire logic [ADC_W-1:0] adc_rectified_supply_node_in,
  input wire logic             uvlo_ok_in,
  input wire logic             vin_over_in,
  input wire logic             en_pin_in,
  input wire logic             power_xfer_in,
  input wire logic             freq_down_out,
  input wire logic             freq_up_out,
  input wire logic             ept_req_out,
  input wire logic             ldo_en_out,
  input wire logic [1:0]       rect_mode_out,
  input wire logic             tank_clamp_out,
  input wire logic             input_clamp_out,
  input wire logic             stat_n_out
);
  localparam int DB  = DEADBAND_MV / MV_PER_LSB;
  localparam int OVC = OVP_MV / MV_PER_LSB;
  localparam int RLC = (OVP_MV - HYST_MV) / MV_PER_LSB;
  localparam int TOP = RECTIFIED_SUPPLY_NODE_LDO_MV / MV_PER_LSB;
  localparam int LOW = RECTIFIED_SUPPLY_NODE_T3_MV / MV_PER_LSB;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Pin levels held long enough to pass the synchronisers
  sequence en_held; en_pin_in[*8]; endsequence
  sequence ovin_held; (vin_over_in && uvlo_ok_in && !en_pin_in)[*8];
  endsequence
  sequence low_held; !uvlo_ok_in[*8]; endsequence
  sequence cool_sample; adc_done_in && adc_rectified_supply_node_in < RLC; endsequence
  down_dir_a:
    assert property (freq_down_out |-> $past(adc_rectified_supply_node_in, 2) + DB < TOP)
    else $error("lower request with high voltage");
  up_dir_a:
    assert property (freq_up_out |-> $past(adc_rectified_supply_node_in, 2) > LOW + DB)
    else $error("raise request with low voltage");
  ldo_gate_a:
    assert property ($rose(ldo_en_out) |-> $past(power_xfer_in))
    else $error("regulator on outside transfer");
  stat_ldo_a:
    assert property (stat_n_out == !ldo_en_out)
    else $error("status pin disagrees with regulator");
  clamp_set_a:
    assert property (adc_done_in && adc_rectified_supply_node_in > OVC |-> ##2 tank_clamp_out)
    else $error("clamp missed overvoltage");
  clamp_rel_a:
    assert property (cool_sample |-> ##2 !tank_clamp_out)
    else $error("clamp kept below release level");
  ept_pulse_a:
    assert property ($rose(en_pin_in) && uvlo_ok_in && !vin_over_in
                     |-> ##[2:8] ept_req_out)
    else $error("no end packet after disable");
  en_off_a:
    assert property (en_held |-> !ldo_en_out)
    else $error("regulator on while disabled");
  ovin_a:
    assert property (ovin_held |-> input_clamp_out && !ldo_en_out)
    else $error("over-input not handled");
  diode_a:
    assert property (low_held |-> rect_mode_out == 2'h0)
    else $error("switches driven below lockout");
endmodule
